/* shared/mipu_pkg.sv */
package mipu_pkg;

  // register indexes; byte address on the bus is four times the index
  localparam logic [5:0] IDX_MISC = 6'h0C;
  localparam logic [5:0] IDX_WAKE_EN = 6'h0D;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h0E;
  localparam logic [5:0] IDX_TCTRL = 6'h12;
  localparam logic [5:0] IDX_TSTAT = 6'h13;
  localparam logic [5:0] IDX_ASSOC_ICAP = 6'h14;
  localparam logic [5:0] IDX_ASSOC_OCMP = 6'h16;
  localparam logic [5:0] IDX_ASSOC_OVF = 6'h18;

  // miscellaneous register layout
  localparam int MISC_RISE_BIT = 6;
  localparam int MISC_FALL_BIT = 5;
  localparam logic [7:0] MISC_RST = 8'h10;
  localparam logic [7:0] MISC_WR_FREE = 8'h03;

  // timer control/status: enables and flags share positions 7..5
  localparam int TMR_LSB = 5;
  localparam int TMR_ICAP = 2;
  localparam int TMR_OCMP = 1;
  localparam int TMR_OVF = 0;
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;

  // service vectors
  localparam logic [15:0] VEC_RESET = 16'h1FFE;
  localparam logic [15:0] VEC_TRAP = 16'h1FFC;
  localparam logic [15:0] VEC_EXT = 16'h1FFA;
  localparam logic [15:0] VEC_ICAP = 16'h1FF8;
  localparam logic [15:0] VEC_OCMP = 16'h1FF6;
  localparam logic [15:0] VEC_OVF = 16'h1FF4;
  localparam logic [15:0] VEC_WAKE = 16'h1FF0;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_RESET,
    SRC_TRAP,
    SRC_EXT,
    SRC_ICAP,
    SRC_OCMP,
    SRC_OVF,
    SRC_WAKE
  } mipu_src_t;

  // events from the cpu core, each a one-cycle pulse except rti_mask
  typedef struct packed {
    logic boundary;
    logic trap;
    logic wait_e;
    logic halt_e;
    logic rti;
    logic rti_mask;
    logic sei;
    logic cli;
  } mipu_cpu_t;

  // service order to the cpu core
  typedef struct packed {
    logic take;
    mipu_src_t src;
    logic [15:0] vector;
    logic push_pc;
    logic push_x;
    logic push_a;
    logic push_cc;
    logic push_y;
    logic stacked_mask;
  } mipu_svc_t;

endpackage

/* hw/mipu_core.sv */
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - reset sets the interrupt mask, disabling maskable interrupts
// - entering wait or halt clears the mask
// - sources: external pin, wake-up port, timer, plus software trap
// - service pushes pc, x, a, cc, not y, then sets mask
// - after stacking, pc loads the serviced source's vector
// - return restores registers; mask clears only if stacked mask zero
// - priority: reset, trap, ext, capture, compare, overflow, wake-up
// - while masked only the trap is accepted
// - trap recognised when executed, regardless of mask
// - trigger codes: 00 fall+low, 01 fall, 10 rise, 11 both
// - trigger option writes ignored while mask is clear
// - changing trigger options discards pending external request
// - maskable interrupts taken only at instruction boundary
// - one external edge latched while masked; low level never latched
// - line still low after service is recognised again at the next enabled boundary
// - falling edge on an enabled wake-up pin raises a request
// - one wake-up edge latched while masked, cleared at service
// - timer request needs flag, enable and clear mask, else pending
// - timer flags in status register, enables in control register
// - status access then associated access clears flag and pending
// - rising select at bit 6, falling select at bit 5
module mipu_core
  import mipu_pkg::*;
#(
  parameter int WAKE_PINS = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu core
  input wire mipu_cpu_t cpu_i,
  output mipu_svc_t svc_o,
  output logic mask_o,
  // pins and timer
  input wire logic ext_irq_i,
  input wire logic [WAKE_PINS-1:0] wakeup_port_pins_i,
  input wire logic [2:0] tmr_flag_set_i,
  output logic [7:0] misc_o
);

  if (WAKE_PINS < 1 || WAKE_PINS > 8) begin : g_chk
    $error("WAKE_PINS must be 1 to 8");
  end

  function automatic logic [15:0] vec_of(input mipu_src_t s);
    logic [15:0] v;
    v = VEC_RESET;
    unique case (s)
      SRC_NONE: v = VEC_RESET;
      SRC_RESET: v = VEC_RESET;
      SRC_TRAP: v = VEC_TRAP;
      SRC_EXT: v = VEC_EXT;
      SRC_ICAP: v = VEC_ICAP;
      SRC_OCMP: v = VEC_OCMP;
      SRC_OVF: v = VEC_OVF;
      SRC_WAKE: v = VEC_WAKE;
    endcase
    return v;
  endfunction

  function automatic logic [5:0] assoc_idx(input int k);
    logic [5:0] r;
    r = IDX_ASSOC_OVF;
    if (k == TMR_ICAP) begin
      r = IDX_ASSOC_ICAP;
    end else if (k == TMR_OCMP) begin
      r = IDX_ASSOC_OCMP;
    end
    return r;
  endfunction

  logic mask_r;
  logic [7:0] misc_r;
  logic [7:0] tctrl_r;
  logic [7:0] wake_en_r;
  logic ack_r;
  logic [31:0] dat_r;
  mipu_svc_t svc_r;
  logic ext_s1_r, ext_s2_r, ext_d_r;
  logic [WAKE_PINS-1:0] wk_s1_r, wk_s2_r, wk_d_r;
  logic ext_pend_r;
  logic wake_pend_r;
  logic [2:0] tflag_r;
  logic [2:0] tarm_r;

  logic wb_req, wb_fire, wr;
  logic [5:0] idx;
  logic [7:0] rd_byte;
  logic opt_wr, opt_chg;
  logic rise_sel, fall_sel;
  logic ext_rise, ext_fall, edge_hit, level_req, ext_req;
  logic wake_hit;
  logic [2:0] tmr_req;
  logic [2:0] tmr_clr;
  logic take_now;
  mipu_src_t src_now;

  // bus slave: one wait state, ack for exactly one cycle
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_fire = wb_req & ack_r;
  assign idx = wb_adr_i[7:2];
  assign wr = wb_fire & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req & ~ack_r;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_MISC: rd_byte = misc_r;
      IDX_WAKE_EN: rd_byte = wake_en_r;
      IDX_IRQ_STAT: rd_byte = {3'h0, wake_pend_r, ext_pend_r,
                               ext_s2_r, 1'b0, mask_r};
      IDX_TCTRL: rd_byte = tctrl_r;
      IDX_TSTAT: rd_byte = {tflag_r, 5'h00};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_req & ~ack_r) begin
      dat_r <= {24'h00_0000, rd_byte};
    end
  end

  // option writes only land while masked; a change drops the pending edge
  assign opt_wr = wr & (idx == IDX_MISC) & mask_r;
  assign opt_chg = opt_wr &
    (wb_dat_i[MISC_RISE_BIT:MISC_FALL_BIT] !=
     misc_r[MISC_RISE_BIT:MISC_FALL_BIT]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      misc_r <= MISC_RST;
    end else begin
      if (wr && idx == IDX_MISC) begin
        misc_r[1:0] <= wb_dat_i[1:0] & MISC_WR_FREE[1:0];
      end
      if (opt_wr) begin
        misc_r[MISC_RISE_BIT] <= wb_dat_i[MISC_RISE_BIT];
        misc_r[MISC_FALL_BIT] <= wb_dat_i[MISC_FALL_BIT];
      end
    end
  end
  assign misc_o = misc_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tctrl_r <= TCTRL_RST;
      wake_en_r <= WAKE_EN_RST;
    end else begin
      if (wr && idx == IDX_TCTRL) begin
        tctrl_r <= wb_dat_i[7:0];
      end
      if (wr && idx == IDX_WAKE_EN) begin
        wake_en_r <= wb_dat_i[7:0];
      end
    end
  end

  // external pin: two-stage sync, then a history stage for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_d_r <= 1'b1;
    end else begin
      ext_s1_r <= ext_irq_i;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
    end
  end

  assign rise_sel = misc_r[MISC_RISE_BIT];
  assign fall_sel = misc_r[MISC_FALL_BIT];
  assign ext_rise = ~ext_d_r & ext_s2_r;
  assign ext_fall = ext_d_r & ~ext_s2_r;
  assign edge_hit = (ext_fall & (~rise_sel | fall_sel)) |
                    (ext_rise & rise_sel);
  // low level is requested live, never latched, so a wired-or line that
  // stays low is seen again at the next enabled boundary
  assign level_req = ~rise_sel & ~fall_sel & ~ext_s2_r;
  assign ext_req = ext_pend_r | level_req;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_pend_r <= 1'b0;
    end else if (opt_chg) begin
      ext_pend_r <= 1'b0;
    end else if (edge_hit) begin
      ext_pend_r <= 1'b1;
    end else if (take_now && src_now == SRC_EXT) begin
      ext_pend_r <= 1'b0;
    end
  end

  // wake-up port: falling edge on any enabled pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wk_s1_r <= '1;
      wk_s2_r <= '1;
      wk_d_r <= '1;
    end else begin
      wk_s1_r <= wakeup_port_pins_i;
      wk_s2_r <= wk_s1_r;
      wk_d_r <= wk_s2_r;
    end
  end

  assign wake_hit = |(wk_d_r & ~wk_s2_r &
                      wake_en_r[WAKE_PINS-1:0]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_pend_r <= 1'b0;
    end else if (wake_hit) begin
      wake_pend_r <= 1'b1;
    end else if (take_now && src_now == SRC_WAKE) begin
      wake_pend_r <= 1'b0;
    end
  end

  // timer flags: cleared by status access then associated access
  for (genvar k = 0; k < 3; k++) begin : g_tmr
    assign tmr_clr[k] = wb_fire & (idx == assoc_idx(k)) & tarm_r[k];
    assign tmr_req[k] = tflag_r[k] & tctrl_r[TMR_LSB+k];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tflag_r[k] <= 1'b0;
        tarm_r[k] <= 1'b0;
      end else begin
        // a new flag in the clearing cycle survives
        tflag_r[k] <= tmr_flag_set_i[k] |
                      (tflag_r[k] & ~tmr_clr[k]);
        if (tmr_clr[k] || !tflag_r[k]) begin
          tarm_r[k] <= 1'b0;
        end else if (wb_fire && idx == IDX_TSTAT) begin
          tarm_r[k] <= 1'b1;
        end
      end
    end
  end

  // arbitration: trap at once, maskable only at a boundary while unmasked
  always_comb begin
    src_now = SRC_NONE;
    if (cpu_i.trap) begin
      src_now = SRC_TRAP;
    end else if (cpu_i.boundary && !mask_r) begin
      if (ext_req) begin
        src_now = SRC_EXT;
      end else if (tmr_req[TMR_ICAP]) begin
        src_now = SRC_ICAP;
      end else if (tmr_req[TMR_OCMP]) begin
        src_now = SRC_OCMP;
      end else if (tmr_req[TMR_OVF]) begin
        src_now = SRC_OVF;
      end else if (wake_pend_r) begin
        src_now = SRC_WAKE;
      end
    end
  end
  assign take_now = (src_now != SRC_NONE);

  // service order, one pulse per taken interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svc_r <= '0;
    end else begin
      svc_r.take <= take_now;
      svc_r.src <= src_now;
      svc_r.vector <= vec_of(src_now);
      svc_r.push_pc <= take_now;
      svc_r.push_x <= take_now;
      svc_r.push_a <= take_now;
      svc_r.push_cc <= take_now;
      svc_r.push_y <= 1'b0;
      svc_r.stacked_mask <= mask_r;
    end
  end
  assign svc_o = svc_r;

  // global mask bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= 1'b1;
    end else if (take_now) begin
      mask_r <= 1'b1;
    end else if (cpu_i.rti) begin
      mask_r <= cpu_i.rti_mask;
    end else if (cpu_i.wait_e || cpu_i.halt_e) begin
      mask_r <= 1'b0;
    end else if (cpu_i.sei) begin
      mask_r <= 1'b1;
    end else if (cpu_i.cli) begin
      mask_r <= 1'b0;
    end
  end
  assign mask_o = mask_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ext_taken;
    take_now && src_now == SRC_EXT && !edge_hit && !opt_chg;
  endsequence

  sequence s_tstat_armed;
    wb_fire && idx == IDX_TSTAT && tflag_r[TMR_OVF];
  endsequence

  property p_reset_mask;
    $fell(rst_i) |-> mask_r;
  endproperty
  a_reset_mask: assert property (p_reset_mask)
    else $error("mask not set after reset");

  property p_wait_clear;
    (cpu_i.wait_e || cpu_i.halt_e) && !take_now && !cpu_i.rti
      |=> !mask_r;
  endproperty
  a_wait_clear: assert property (p_wait_clear)
    else $error("mask not cleared on wait or halt");

  property p_take_stack;
    take_now |=> svc_o.take && mask_r && svc_o.push_cc && !svc_o.push_y;
  endproperty
  a_take_stack: assert property (p_take_stack)
    else $error("service order or mask wrong");

  property p_vector;
    svc_o.take |-> svc_o.vector == vec_of(svc_o.src);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector does not match source");

  property p_rti;
    cpu_i.rti && !take_now |=> mask_r == $past(cpu_i.rti_mask);
  endproperty
  a_rti: assert property (p_rti)
    else $error("return did not restore mask");

  property p_masked_trap_only;
    svc_o.take && svc_o.src != SRC_TRAP |-> !$past(mask_r);
  endproperty
  a_masked_trap_only: assert property (p_masked_trap_only)
    else $error("maskable source taken while masked");

  property p_trap_now;
    cpu_i.trap |=> svc_o.take && svc_o.src == SRC_TRAP;
  endproperty
  a_trap_now: assert property (p_trap_now)
    else $error("trap not taken at once");

  property p_boundary;
    svc_o.take && svc_o.src != SRC_TRAP |-> $past(cpu_i.boundary);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("maskable source taken off a boundary");

  property p_opt_locked;
    wr && idx == IDX_MISC && !mask_r
      |=> $stable(misc_r[MISC_RISE_BIT:MISC_FALL_BIT]);
  endproperty
  a_opt_locked: assert property (p_opt_locked)
    else $error("trigger options changed while unmasked");

  property p_opt_drop;
    opt_chg |=> !ext_pend_r;
  endproperty
  a_opt_drop: assert property (p_opt_drop)
    else $error("pending external kept across option change");

  property p_ext_once;
    s_ext_taken |=> !ext_pend_r;
  endproperty
  a_ext_once: assert property (p_ext_once)
    else $error("external latch not cleared at service");

  property p_ext_prio;
    take_now && !cpu_i.trap && ext_req |-> src_now == SRC_EXT;
  endproperty
  a_ext_prio: assert property (p_ext_prio)
    else $error("external request lost priority");

  property p_tmr_clear;
    s_tstat_armed ##1 !wb_req ##1 (wb_req && !ack_r) ##1
      (wb_fire && idx == IDX_ASSOC_OVF && !tmr_flag_set_i[TMR_OVF])
      |=> !tflag_r[TMR_OVF];
  endproperty
  a_tmr_clear: assert property (p_tmr_clear)
    else $error("overflow flag not cleared by sequence");

endmodule

/* verification/mipu_far_model.sv */
`timescale 1ns/1ps
module mipu_far_model
  import mipu_pkg::*;
(
  // clock
  input wire logic clk_i,
  // service order from the block
  input wire mipu_svc_t svc_i,
  // core events, pins and timer
  output mipu_cpu_t cpu_o,
  output logic ext_o,
  output logic [5:0] wake_o,
  output logic [2:0] tmr_o
);
  int got;
  mipu_svc_t last;

  // pin lines idle high, timer and core lines low: the ext pin is tied up when unused
  initial begin
    cpu_o = '0;
    ext_o = 1'h1;
    wake_o = 6'h3F;
    tmr_o = 3'h0;
    got = 0;
  end

  // core issues each event for one cycle only
  task automatic evt(input mipu_cpu_t e);
    @(posedge clk_i);
    cpu_o <= e;
    @(posedge clk_i);
    cpu_o <= '0;
    repeat (3) @(posedge clk_i);
  endtask

  // level held long past sync delay; pulses spaced past service
  task automatic pin(input logic v);
    @(posedge clk_i);
    ext_o <= v;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic wk(input logic [5:0] v);
    @(posedge clk_i);
    wake_o <= v;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic tmr(input logic [2:0] f);
    @(posedge clk_i);
    tmr_o <= f;
    @(posedge clk_i);
    tmr_o <= 3'h0;
  endtask

  always @(posedge clk_i) begin
    if (svc_i.take === 1'h1) begin
      got <= got + 1;
      last <= svc_i;
    end
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_top
  import mipu_pkg::*;
;
  localparam mipu_cpu_t BND = '{boundary: 1'h1, default: 1'h0};
  localparam mipu_cpu_t TRP = '{trap: 1'h1, default: 1'h0};
  localparam mipu_cpu_t SEI = '{sei: 1'h1, default: 1'h0};
  localparam mipu_cpu_t CLI = '{cli: 1'h1, default: 1'h0};
  localparam mipu_cpu_t WTE = '{wait_e: 1'h1, default: 1'h0};
  localparam mipu_cpu_t HLT = '{halt_e: 1'h1, default: 1'h0};
  localparam mipu_cpu_t RT0 = '{rti: 1'h1, default: 1'h0};
  localparam mipu_cpu_t RT1 = '{rti: 1'h1, rti_mask: 1'h1, default: 1'h0};
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc, stb, we, ack, ext, mask;
  logic [7:0] adr, misc;
  logic [3:0] sel, lane;
  logic [31:0] wdat, rdat;
  logic [5:0] wake;
  logic [2:0] tmr;
  mipu_cpu_t cpu;
  mipu_svc_t svc;
  int fail_count = 0, checked = 0, ng = 0;
  mipu_src_t srcs [4] = '{SRC_EXT, SRC_ICAP, SRC_OVF, SRC_WAKE};
  logic [15:0] vecs [4] = '{VEC_EXT, VEC_ICAP, VEC_OVF, VEC_WAKE};
  logic [5:0] aso [4] = '{6'h00, IDX_ASSOC_ICAP, IDX_ASSOC_OVF, 6'h00};

  always #20 clk_i = ~clk_i;

  mipu_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_i(cpu),
    .svc_o(svc), .mask_o(mask), .ext_irq_i(ext),
    .wakeup_port_pins_i(wake), .tmr_flag_set_i(tmr), .misc_o(misc));
  mipu_far_model far (.clk_i(clk_i), .svc_i(svc), .cpu_o(cpu),
    .ext_o(ext), .wake_o(wake), .tmr_o(tmr));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // request held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [5:0] i,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, sel} <= {2'h3, w, lane};
    adr <= {i, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 50);
    q = rdat;
    `CHK("ack", 1'h1, ack)
    {cyc, stb, we, sel} <= 7'h00;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    wb(1'h1, i, d, q);
  endtask

  task automatic rdc(input string n, input logic [5:0] i,
                     input logic [7:0] e);
    logic [31:0] q;
    wb(1'h0, i, 8'h00, q);
    `CHK(n, {24'h0, e}, q)
  endtask

  // status access arms, associated access clears
  task automatic clr(input logic [5:0] a);
    logic [31:0] q;
    wb(1'h0, IDX_TSTAT, 8'h00, q);
    wb(1'h0, a, 8'h00, q);
  endtask

  task automatic took(input mipu_src_t s, input logic [15:0] v);
    logic [4:0] p;
    ng++;
    p = {far.last.push_pc, far.last.push_x, far.last.push_a,
         far.last.push_cc, far.last.push_y};
    `CHK("takes", ng, far.got)
    `CHK("src", s, far.last.src)
    `CHK("vector", v, far.last.vector)
    `CHK("push", 5'h1E, p)
    `CHK("stacked", s == SRC_TRAP, far.last.stacked_mask)
    `CHK("mask", 1'h1, mask)
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    close_out();
  end

  initial begin
    {cyc, stb, we, sel, lane} <= 11'h001;
    adr <= 8'h00;
    wdat <= 32'h0000_0000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    `CHK("mask", 1'h1, mask)
    `CHK("misc_o", MISC_RST, misc)
    rdc("misc", IDX_MISC, MISC_RST);
    rdc("tctrl", IDX_TCTRL, TCTRL_RST);
    rdc("wake_en", IDX_WAKE_EN, WAKE_EN_RST);
    rdc("unmapped", 6'h3F, 8'h00);
    tend("reset");
    wr(IDX_MISC, 8'h50);
    rdc("misc", IDX_MISC, 8'h50);
    far.evt(CLI);
    wr(IDX_MISC, 8'h33);
    rdc("misc", IDX_MISC, 8'h53);
    `CHK("misc_o", 8'h53, misc)
    // a write without the low byte lane must leave the register alone
    lane <= 4'hE;
    wr(IDX_MISC, 8'h00);
    lane <= 4'h1;
    rdc("sel", IDX_MISC, 8'h53);
    tend("option lock");
    far.evt(SEI);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MISC, {1'h0, c[1], c[0], 5'h10});
      rdc("pend", IDX_IRQ_STAT, 8'h05);
      far.pin(1'h0);
      rdc("fall", IDX_IRQ_STAT, (c != 2) ? 8'h09 : 8'h01);
      far.pin(1'h1);
      rdc("rise", IDX_IRQ_STAT, 8'h0D);
    end
    tend("trigger modes");
    wr(IDX_WAKE_EN, 8'h01);
    far.wk(6'h3E);
    wr(IDX_TCTRL, 8'hA0);
    far.tmr(3'h7);
    rdc("tstat", IDX_TSTAT, 8'hE0);
    far.evt(BND);
    `CHK("takes", ng, far.got)
    far.evt(TRP);
    took(SRC_TRAP, VEC_TRAP);
    for (int k = 0; k < 4; k++) begin
      far.evt(CLI);
      `CHK("takes", ng, far.got)
      far.evt(BND);
      took(srcs[k], vecs[k]);
      if (aso[k] != 6'h00) clr(aso[k]);
    end
    far.wk(6'h3F);
    rdc("tstat", IDX_TSTAT, 8'h40);
    far.evt(CLI);
    far.evt(BND);
    `CHK("takes", ng, far.got)
    wr(IDX_TCTRL, 8'h40);
    far.evt(BND);
    took(SRC_OCMP, VEC_OCMP);
    clr(IDX_ASSOC_OCMP);
    tend("priority");
    far.evt(CLI);
    far.evt(RT1);
    `CHK("mask", 1'h1, mask)
    far.evt(RT0);
    `CHK("mask", 1'h0, mask)
    far.evt(SEI);
    far.evt(WTE);
    `CHK("mask", 1'h0, mask)
    far.evt(SEI);
    far.evt(HLT);
    `CHK("mask", 1'h0, mask)
    tend("mask");
    far.evt(SEI);
    wr(IDX_MISC, 8'h10);
    far.pin(1'h0);
    far.evt(CLI);
    far.evt(BND);
    took(SRC_EXT, VEC_EXT);
    far.evt(CLI);
    far.evt(BND);
    took(SRC_EXT, VEC_EXT);
    rdc("level", IDX_IRQ_STAT, 8'h01);
    far.pin(1'h1);
    tend("wired or");
    close_out();
  end
endmodule
